// ===== design/srp_defines.svh
// constants of the serial receive path select and status block
// assumes inclusion by bare name from package and modules
//
// Summary of operation
// - primary serial out driven only when enabled
// - redundant serial out driven only when enabled
// - rx byte launched on recovered or reference clock
// - idle flag marks presented idle character
// - special flag marks presented K character
// - error flag on code or disparity fault
// - bypass mode: flags carry bit8, bit9, comma
// - recovered clock from channel A or own
// - unused recovered clock: true low, complement high
// - common timing select times all receive byte, flag and status outputs, not the recovered clock pair
// - normal loop, select high: primary input used
// - normal loop, select low: redundant input used
// - two loopback bits pick normal, serial, parallel
// - primary detect hysteresis, registered with data
// - redundant detect hysteresis, launched with data
// - coding enable picks decoded or raw interface
// - half rate select divides recovered clock
`ifndef SRP_DEFINES_SVH
`define SRP_DEFINES_SVH

`define SRP_NUM_CH        4
`define SRP_FIFO_DEPTH    4
`define SRP_BYTE_W        8

// receive timing select codes
`define SRP_RM_OWN_REC    2'h0
`define SRP_RM_CHA_REC    2'h1
`define SRP_RM_REF_NOCLK  2'h2
`define SRP_RM_REF_OWN    2'h3
`define SRP_RM_REF_BIT    1

// loopback control codes
`define SRP_LB_NORMAL     2'h0
`define SRP_LB_PARALLEL   2'h1
`define SRP_LB_SERIAL_BIT 1

// idle level of the inverted recovered clock storage
`define SRP_RCLK_LOW      1'h0

`endif

// ===== design/srp_pkg.sv
// types of the serial receive path select and status block
// assumes the defines header is on the include path
`include "srp_defines.svh"

package srp_pkg;

  // one word from the decoder
  typedef struct packed {
    logic [`SRP_BYTE_W-1:0] data;
    logic                   isIdle;
    logic                   isSpecial;
    logic                   codeErr;
    logic                   dispErr;
    logic                   raw8;
    logic                   raw9;
    logic                   comma;
  } srp_dec_word_t;

  // per-channel inputs from outside the clock domain
  typedef struct packed {
    logic       priIn;
    logic       redIn;
    logic       recClk;
    logic       priHi;
    logic       priLo;
    logic       redHi;
    logic       redLo;
    logic       txEnP;
    logic       txEnR;
    logic [1:0] lb;
    logic       rxSel;
  } srp_async_ch_t;

  // global inputs from outside the clock domain
  typedef struct packed {
    logic       reference_clock_in;
    logic       codingEn;
    logic [1:0] rmode;
    logic       halfRate;
  } srp_async_glb_t;

  // per-channel state of the path block
  typedef struct packed {
    logic                   timPrev;
    logic                   srcPrev;
    logic                   rclk;
    logic                   rclkInvN;
    logic                   priDetLive;
    logic                   redDetLive;
    logic [`SRP_BYTE_W-1:0] rxByte;
    logic                   rxValid;
    logic                   idleFlag;
    logic                   specFlag;
    logic                   errFlag;
    logic                   priDet;
    logic                   redDet;
    logic                   txBufErr;
    logic                   priOut;
    logic                   priOe;
    logic                   redOut;
    logic                   redOe;
    logic                   deserBit;
    logic                   parLoop;
  } srp_chan_state_t;

endpackage : srp_pkg

// ===== design/srp_sync.sv
// two flip-flop synchroniser for a vector of asynchronous levels
// assumes each bit is an independent level
`timescale 1ns/100ps

module srp_sync
  import srp_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } srp_sync_state_t;

  srp_sync_state_t st_ff;
  srp_sync_state_t nxt_st;

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.stage1 = asyncIn;
    nxt_st.stage2 = st_ff.stage1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign syncOut = st_ff.stage2;

endmodule : srp_sync

// ===== design/srp_fifo.sv
// small word fifo with valid and ready on both sides
// assumes same clock on both sides
`timescale 1ns/100ps
`include "srp_defines.svh"

module srp_fifo
  import srp_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SRP_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wrPtr;
    logic [PTR_W-1:0]            rdPtr;
    logic [CNT_W-1:0]            count;
  } srp_fifo_state_t;

  srp_fifo_state_t st_ff;
  srp_fifo_state_t nxt_st;
  logic            push;
  logic            pop;

  always_comb begin
    nxt_st   = st_ff;
    inReady  = (st_ff.count != FULL);
    outValid = (st_ff.count != '0);
    outData  = st_ff.mem[st_ff.rdPtr];
    push     = inValid && inReady;
    pop      = outValid && outReady;
    if (push) begin
      nxt_st.mem[st_ff.wrPtr] = inData;
      nxt_st.wrPtr = (st_ff.wrPtr == LAST) ? '0 : st_ff.wrPtr + 1'b1;
    end
    if (pop) begin
      nxt_st.rdPtr = (st_ff.rdPtr == LAST) ? '0 : st_ff.rdPtr + 1'b1;
    end
    unique case ({push, pop})
      2'b10:   nxt_st.count = st_ff.count + 1'b1;
      2'b01:   nxt_st.count = st_ff.count - 1'b1;
      default: nxt_st.count = st_ff.count;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : srp_fifo

// ===== design/srp_rx_path.sv
// per-channel serial path select and receive output stage
// assumes decoder, serializer and deserializer run on clk;
// clocks and analog comparator levels arrive as async pins
`timescale 1ns/100ps
`include "srp_defines.svh"

module srp_rx_path
  import srp_pkg::*;
#(
  parameter int NUM_CH     = `SRP_NUM_CH,
  parameter int FIFO_DEPTH = `SRP_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                             clk,
  input  wire logic                             resetn,

  // global configuration pins
  input  wire logic                             codingEnable,
  input  wire logic [1:0]                       rxTimingSelect,
  input  wire logic                             halfRateSelect,
  input  wire logic                             referenceClockIn,

  // per-channel configuration pins
  input  wire logic [NUM_CH-1:0]                primaryTxEnable,
  input  wire logic [NUM_CH-1:0]                redundantTxEnable,
  input  wire logic [NUM_CH-1:0][1:0]           loopbackControl,
  input  wire logic [NUM_CH-1:0]                rxSourceSelect,

  // per-channel serial and analog pins
  input  wire logic [NUM_CH-1:0]                primarySerialIn,
  input  wire logic [NUM_CH-1:0]                redundantSerialIn,
  input  wire logic [NUM_CH-1:0]                recClkIn,
  input  wire logic [NUM_CH-1:0]                priAmpAboveHigh,
  input  wire logic [NUM_CH-1:0]                priAmpBelowLow,
  input  wire logic [NUM_CH-1:0]                redAmpAboveHigh,
  input  wire logic [NUM_CH-1:0]                redAmpBelowLow,

  // serializer side
  input  wire logic [NUM_CH-1:0]                txSerialBit,
  output logic      [NUM_CH-1:0]                primarySerialOut,
  output logic      [NUM_CH-1:0]                primarySerialOutEn,
  output logic      [NUM_CH-1:0]                redundantSerialOut,
  output logic      [NUM_CH-1:0]                redundantSerialOutEn,

  // deserializer side
  output logic      [NUM_CH-1:0]                deserInBit,
  output logic      [NUM_CH-1:0]                parallelLoopEnable,

  // decoder side
  input  wire logic [NUM_CH-1:0]                decValid,
  output logic      [NUM_CH-1:0]                decReady,
  input  wire srp_dec_word_t [NUM_CH-1:0]       decWord,

  // transmit skew buffer status
  input  wire logic [NUM_CH-1:0]                txSkewBufErrIn,

  // receive outputs
  output logic      [NUM_CH-1:0][`SRP_BYTE_W-1:0] rxDataByte,
  output logic      [NUM_CH-1:0]                rxDataValid,
  output logic      [NUM_CH-1:0]                idleDetectFlag,
  output logic      [NUM_CH-1:0]                specialCharFlag,
  output logic      [NUM_CH-1:0]                codeErrorFlag,
  output logic      [NUM_CH-1:0]                primarySignalDetect,
  output logic      [NUM_CH-1:0]                redundantSignalDetect,
  output logic      [NUM_CH-1:0]                txSkewBufferError,
  output logic      [NUM_CH-1:0]                recoveredClockOut,
  output logic      [NUM_CH-1:0]                recoveredClockOutInv
);

  localparam int CH_W  = $bits(srp_async_ch_t);
  localparam int GLB_W = $bits(srp_async_glb_t);
  localparam int SYN_W = CH_W * NUM_CH + GLB_W;

  // whole block state, one entry per channel
  typedef struct packed {
    srp_chan_state_t [NUM_CH-1:0] ch;
  } srp_main_state_t;

  // ==========================================================
  // input synchronisation
  // ==========================================================
  srp_async_ch_t [NUM_CH-1:0] rawCh;
  srp_async_ch_t [NUM_CH-1:0] syncCh;
  srp_async_glb_t             rawGlb;
  srp_async_glb_t             syncGlb;
  logic [SYN_W-1:0]           syncVec;

  always_comb begin
    rawGlb.reference_clock_in   = referenceClockIn;
    rawGlb.codingEn = codingEnable;
    rawGlb.rmode    = rxTimingSelect;
    rawGlb.halfRate = halfRateSelect;

    for (int c = 0; c < NUM_CH; c++) begin
      rawCh[c].priIn  = primarySerialIn[c];
      rawCh[c].redIn  = redundantSerialIn[c];
      rawCh[c].recClk = recClkIn[c];
      rawCh[c].priHi  = priAmpAboveHigh[c];
      rawCh[c].priLo  = priAmpBelowLow[c];
      rawCh[c].redHi  = redAmpAboveHigh[c];
      rawCh[c].redLo  = redAmpBelowLow[c];
      rawCh[c].txEnP  = primaryTxEnable[c];
      rawCh[c].txEnR  = redundantTxEnable[c];
      rawCh[c].lb     = loopbackControl[c];
      rawCh[c].rxSel  = rxSourceSelect[c];
    end
  end

  // every async pin level in rawCh and rawGlb passes two flip-flops
  srp_sync #(
    .WIDTH (SYN_W)
  ) u_sync (
    .clk     (clk),
    .resetn  (resetn),
    .asyncIn ({rawCh, rawGlb}),
    .syncOut (syncVec)
  );

  // same order as packed above
  assign {syncCh, syncGlb} = syncVec;

  // ==========================================================
  // decoder word buffers
  // ==========================================================
  logic          [NUM_CH-1:0] fifoValid;
  logic          [NUM_CH-1:0] fifoPop;
  srp_dec_word_t [NUM_CH-1:0] fifoWord;

  // one word buffer per channel
  for (genvar g = 0; g < NUM_CH; g++) begin : g_fifo
    srp_fifo #(
      .WIDTH ($bits(srp_dec_word_t)),
      .DEPTH (FIFO_DEPTH)
    ) u_fifo (
      .clk      (clk),
      .resetn   (resetn),
      .inValid  (decValid[g]),
      .inReady  (decReady[g]),
      .inData   (decWord[g]),
      .outValid (fifoValid[g]),
      .outReady (fifoPop[g]),
      .outData  (fifoWord[g])
    );
  end

  // ==========================================================
  // channel logic
  // ==========================================================
  srp_main_state_t st_ff;
  srp_main_state_t nxt_st;

  always_comb begin
    srp_async_ch_t   a;
    srp_chan_state_t s;
    srp_dec_word_t   w;
    logic            rclkSrc;
    logic            rclkUsed;
    logic            timLevel;
    logic            tick;
    logic            srcRise;

    a        = '0;
    s        = '0;
    w        = '0;
    rclkSrc  = 1'b0;
    rclkUsed = 1'b0;
    timLevel = 1'b0;
    tick     = 1'b0;
    srcRise  = 1'b0;

    nxt_st   = st_ff;

    for (int c = 0; c < NUM_CH; c++) begin
      a = syncCh[c];
      s = st_ff.ch[c];
      w = fifoWord[c];

      // recovered clock source: channel A or own
      rclkSrc  = (syncGlb.rmode == `SRP_RM_CHA_REC) ? syncCh[0].recClk
                                                     : a.recClk;
      rclkUsed = (syncGlb.rmode != `SRP_RM_REF_NOCLK);

      // launch reference for byte, flag, detect and status outputs; recovered clock pair follows rclkSrc
      timLevel = syncGlb.rmode[`SRP_RM_REF_BIT] ? syncGlb.reference_clock_in
                                                 : rclkSrc;
      tick     = timLevel && !s.timPrev;
      srcRise  = rclkSrc && !s.srcPrev;
      s.timPrev = timLevel;
      s.srcPrev = rclkSrc;

      // recovered clock outputs
      if (!rclkUsed) begin
        s.rclk     = `SRP_RCLK_LOW;
        s.rclkInvN = `SRP_RCLK_LOW;
      end else if (syncGlb.halfRate) begin
        if (srcRise) begin
          s.rclk     = !s.rclk;
          // copy the new level, output side inverts it
          s.rclkInvN = s.rclk;
        end
      end else begin
        s.rclk     = rclkSrc;
        s.rclkInvN = rclkSrc;
      end

      // signal detect hysteresis, held between thresholds
      if (a.priHi) begin
        s.priDetLive = 1'b1;
      end else if (a.priLo) begin
        s.priDetLive = 1'b0;
      end

      if (a.redHi) begin
        s.redDetLive = 1'b1;
      end else if (a.redLo) begin
        s.redDetLive = 1'b0;
      end

      // serial transmit drivers
      s.priOut = a.txEnP && txSerialBit[c];
      s.priOe  = a.txEnP;
      s.redOut = a.txEnR && txSerialBit[c];
      s.redOe  = a.txEnR;

      // deserializer source select
      if (a.lb[`SRP_LB_SERIAL_BIT]) begin
        s.deserBit = txSerialBit[c];
      end else if (a.rxSel) begin
        s.deserBit = a.priIn;
      end else begin
        s.deserBit = a.redIn;
      end
      s.parLoop = (a.lb == `SRP_LB_PARALLEL);

      // output launch, all fields in one cycle
      fifoPop[c] = tick;
      if (tick) begin
        s.priDet   = s.priDetLive;
        s.redDet   = s.redDetLive;
        s.txBufErr = txSkewBufErrIn[c];

        // empty buffer: byte and flags hold
        if (fifoValid[c]) begin
          s.rxByte = w.data;
          if (syncGlb.codingEn) begin
            s.idleFlag = w.isIdle;
            s.specFlag = w.isSpecial;
            s.errFlag  = w.codeErr || w.dispErr;
            s.rxValid  = !(w.codeErr || w.dispErr);
          end else begin
            s.idleFlag = w.comma;
            s.specFlag = w.raw8;
            s.errFlag  = w.raw9;
            s.rxValid  = 1'b1;
          end
        end
      end
      nxt_st.ch[c] = s;
    end
  end

  // all channel state in one register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      // line and loopback drivers
      primarySerialOut[c]      = st_ff.ch[c].priOut;
      primarySerialOutEn[c]    = st_ff.ch[c].priOe;
      redundantSerialOut[c]    = st_ff.ch[c].redOut;
      redundantSerialOutEn[c]  = st_ff.ch[c].redOe;
      deserInBit[c]            = st_ff.ch[c].deserBit;
      parallelLoopEnable[c]    = st_ff.ch[c].parLoop;

      // byte and flags
      rxDataByte[c]            = st_ff.ch[c].rxByte;
      rxDataValid[c]           = st_ff.ch[c].rxValid;
      idleDetectFlag[c]        = st_ff.ch[c].idleFlag;
      specialCharFlag[c]       = st_ff.ch[c].specFlag;
      codeErrorFlag[c]         = st_ff.ch[c].errFlag;

      // detects and buffer status
      primarySignalDetect[c]   = st_ff.ch[c].priDet;
      redundantSignalDetect[c] = st_ff.ch[c].redDet;
      txSkewBufferError[c]     = st_ff.ch[c].txBufErr;

      // recovered clock pair
      recoveredClockOut[c]     = st_ff.ch[c].rclk;
      // stored inverted so reset gives complement high
      recoveredClockOutInv[c]  = !st_ff.ch[c].rclkInvN;
    end
  end

endmodule : srp_rx_path

// ===== dv/srp_rx_path_monitor.sv
// port-level checker of the receive path block
// assumes bind to every srp_rx_path instance
`timescale 1ns/100ps

module srp_rx_path_mon
  import srp_pkg::*;
#(
  parameter int NUM_CH = 4
) (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   resetn,
  // configuration
  input wire logic [1:0]             rxTimingSelect,
  input wire logic                   halfRateSelect,
  input wire logic [NUM_CH-1:0][1:0] loopbackControl,
  input wire logic [NUM_CH-1:0]      rxSourceSelect,
  // line and serializer side
  input wire logic [NUM_CH-1:0]      primarySerialIn,
  input wire logic [NUM_CH-1:0]      redundantSerialIn,
  input wire logic [NUM_CH-1:0]      recClkIn,
  input wire logic [NUM_CH-1:0]      txSerialBit,
  input wire logic [NUM_CH-1:0]      primarySerialOut,
  input wire logic [NUM_CH-1:0]      primarySerialOutEn,
  input wire logic [NUM_CH-1:0]      redundantSerialOut,
  input wire logic [NUM_CH-1:0]      redundantSerialOutEn,
  input wire logic [NUM_CH-1:0]      deserInBit,
  input wire logic [NUM_CH-1:0]      parallelLoopEnable,
  input wire logic [NUM_CH-1:0]      recoveredClockOut,
  input wire logic [NUM_CH-1:0]      recoveredClockOutInv
);
  // ==========================================
  // assertions
  default clocking mcb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_pri_out_gated: assert property (
    primarySerialOut == ($past(txSerialBit) & primarySerialOutEn))
    else $error("primary serial out wrong for its enable");
  a_red_out_gated: assert property (
    redundantSerialOut == ($past(txSerialBit) & redundantSerialOutEn))
    else $error("redundant serial out wrong for its enable");
  a_rclk_pair_comp: assert property (
    recoveredClockOutInv == ~recoveredClockOut)
    else $error("recovered clock pair not complementary");
  a_rclk_unused_idle: assert property (
    (rxTimingSelect == 2'h2) [*4] |=> recoveredClockOut == '0)
    else $error("unused recovered clock not held low");
  a_rclk_own_follow: assert property (
    (rxTimingSelect == 2'h0 && !halfRateSelect) [*4]
      |-> recoveredClockOut == $past(recClkIn, 3))
    else $error("recovered clock does not follow own source");
  a_rclk_cha_follow: assert property (
    (rxTimingSelect == 2'h1 && !halfRateSelect) [*4]
      |-> recoveredClockOut == {NUM_CH{$past(recClkIn[0], 3)}})
    else $error("recovered clock does not follow channel A");
  a_pri_rx_select: assert property (
    (loopbackControl == '0 && rxSourceSelect == '1) [*4]
      |-> deserInBit == $past(primarySerialIn, 3))
    else $error("deserializer not fed from primary input");
  a_red_rx_select: assert property (
    (loopbackControl == '0 && rxSourceSelect == '0) [*4]
      |-> deserInBit == $past(redundantSerialIn, 3))
    else $error("deserializer not fed from redundant input");
  a_serial_loop_src: assert property (
    (loopbackControl == {NUM_CH{2'h2}}) [*4] |-> deserInBit == $past(txSerialBit))
    else $error("serial loopback not fed from serializer");
  a_parallel_loop_on: assert property (
    (loopbackControl == {NUM_CH{2'h1}}) [*4] |-> parallelLoopEnable == '1)
    else $error("parallel loopback not enabled");
endmodule : srp_rx_path_mon

bind srp_rx_path srp_rx_path_mon #(.NUM_CH(NUM_CH)) mon_u (
  .clk, .resetn, .rxTimingSelect, .halfRateSelect, .loopbackControl,
  .rxSourceSelect, .primarySerialIn, .redundantSerialIn, .recClkIn,
  .txSerialBit, .primarySerialOut, .primarySerialOutEn, .redundantSerialOut,
  .redundantSerialOutEn, .deserInBit, .parallelLoopEnable, .recoveredClockOut,
  .recoveredClockOutInv
);

// ===== dv/srp_far_end.sv
// far-end model: recovered clock and serial line levels
// assumes clk is the block clock; lines move 1 ns after its edge
`timescale 1ns/100ps

module srp_far_end #(
  parameter int NUM_CH = 4
) (
  // clock
  input  wire logic              clk,
  // line side
  output logic      [NUM_CH-1:0] recClkIn,
  output logic      [NUM_CH-1:0] primarySerialIn,
  output logic      [NUM_CH-1:0] redundantSerialIn
);
  // ==========================================
  // line pattern
  logic [7:0] lineCnt = 8'h00;

  always @(posedge clk) begin
    lineCnt <= #1 lineCnt + 8'h01;
  end

  // each channel clock offset by one cycle, period of eight
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      recClkIn[i] = 1'((lineCnt + 8'(i)) >> 2);
    end
    primarySerialIn   = {NUM_CH{lineCnt[0]}} ^ lineCnt[4:1];
    redundantSerialIn = ~primarySerialIn ^ lineCnt[5:2];
  end
endmodule : srp_far_end

// ===== dv/testbench.sv
// self-checking bench of the receive path block
// assumes srp_far_end drives line side; reference clock made here
`timescale 1ns/100ps
`include "srp_defines.svh"

module testbench;
  import srp_pkg::*;
  localparam int NC = `SRP_NUM_CH;
  // ==========================================
  // stimulus and observed signals
  logic                clk = 1'b0;
  logic                resetn = 1'b0;
  logic                codingEnable = 1'b1;
  logic [1:0]          rxTimingSelect = `SRP_RM_REF_OWN;
  logic                halfRateSelect = 1'b0;
  logic                referenceClockIn = 1'b0;
  logic [NC-1:0][1:0]  loopbackControl = '0;
  logic [NC-1:0]       primaryTxEnable = '0, redundantTxEnable = '0, rxSourceSelect = '1;
  logic [NC-1:0]       priAmpAboveHigh = '0, priAmpBelowLow = '0;
  logic [NC-1:0]       redAmpAboveHigh = '0, redAmpBelowLow = '0;
  logic [NC-1:0]       txSerialBit = '0, decValid = '0, txSkewBufErrIn = '0;
  srp_dec_word_t [NC-1:0] decWord = '0;
  logic [NC-1:0]       recClkIn, primarySerialIn, redundantSerialIn, decReady;
  logic [NC-1:0]       primarySerialOut, primarySerialOutEn, redundantSerialOut;
  logic [NC-1:0]       redundantSerialOutEn, deserInBit, parallelLoopEnable;
  logic [NC-1:0]       rxDataValid, idleDetectFlag, specialCharFlag, codeErrorFlag;
  logic [NC-1:0]       primarySignalDetect, redundantSignalDetect, txSkewBufferError;
  logic [NC-1:0]       recoveredClockOut, recoveredClockOutInv;
  logic [NC-1:0][7:0]  rxDataByte;
  int                  miscompares = 0;
  int                  check_count = 0;
  srp_dec_word_t       wordTab [10] = '{{8'h5a, 7'h00}, {8'hbc, 7'h40}, {8'h7c, 7'h20},
    {8'h11, 7'h10}, {8'h22, 7'h08}, {8'h33, 7'h05}, {8'h44, 7'h04}, {8'h55, 7'h02},
    {8'h66, 7'h01}, {8'h77, 7'h58}};

  always #5 clk = ~clk;
  always @(posedge clk) txSerialBit <= #1 txSerialBit + 4'h1;

  srp_far_end #(.NUM_CH(NC)) far_u (.clk, .recClkIn, .primarySerialIn, .redundantSerialIn);

  srp_rx_path dut_u (.clk, .resetn, .codingEnable, .rxTimingSelect, .halfRateSelect,
    .referenceClockIn, .primaryTxEnable, .redundantTxEnable, .loopbackControl,
    .rxSourceSelect, .primarySerialIn, .redundantSerialIn, .recClkIn, .priAmpAboveHigh,
    .priAmpBelowLow, .redAmpAboveHigh, .redAmpBelowLow, .txSerialBit, .primarySerialOut,
    .primarySerialOutEn, .redundantSerialOut, .redundantSerialOutEn, .deserInBit,
    .parallelLoopEnable, .decValid, .decReady, .decWord, .txSkewBufErrIn, .rxDataByte,
    .rxDataValid, .idleDetectFlag, .specialCharFlag, .codeErrorFlag, .primarySignalDetect,
    .redundantSignalDetect, .txSkewBufferError, .recoveredClockOut, .recoveredClockOutInv);

  // ==========================================
  // tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // same word to every channel, held until taken
  task automatic push(input srp_dec_word_t w);
    int t;
    t = 0;
    decWord  = {NC{w}};
    decValid = '1;
    while (decReady !== 4'hf) begin
      if (t == 20) begin
        miscompares++;
        $display("[FAIL] %0t decoder push never taken", $time);
        tally_and_finish();
      end
      step(1);
      t++;
    end
    step(1);
    decValid = '0;
    step(1);
  endtask : push

  task automatic tick();
    referenceClockIn = 1'b1;
    step(6);
    referenceClockIn = 1'b0;
    step(6);
  endtask : tick

  task automatic expect_word(input srp_dec_word_t w);
    logic err;
    err = codingEnable ? (w.codeErr | w.dispErr) : w.raw9;
    check(rxDataByte, {NC{w.data}});
    check(idleDetectFlag, {NC{codingEnable ? w.isIdle : w.comma}});
    check(specialCharFlag, {NC{codingEnable ? w.isSpecial : w.raw8}});
    check(codeErrorFlag, {NC{err}});
    check(rxDataValid, {NC{~codingEnable | ~err}});
  endtask : expect_word

  // ==========================================
  // main sequence
  initial begin
    int i, n;
    logic prev;
    step(4);
    check(recoveredClockOutInv, 4'hf);
    check(decReady, 4'hf);
    step(4);
    resetn = 1'b1;
    step(2);
    $display("test reset done");
    for (i = 0; i < 6; i++) begin
      push(wordTab[i]);
      tick();
      expect_word(wordTab[i]);
    end
    tick();
    expect_word(wordTab[5]);
    $display("test coded words done");
    for (i = 0; i < 4; i++) push(wordTab[i]);
    check(decReady, 4'h0);
    decWord  = {NC{wordTab[9]}};
    decValid = '1;
    step(3);
    check(decReady, 4'h0);
    decValid = '0;
    for (i = 0; i < 5; i++) begin
      tick();
      expect_word(wordTab[(i < 4) ? i : 3]);
    end
    $display("test buffer full done");
    codingEnable = 1'b0;
    step(4);
    for (i = 6; i < 10; i++) begin
      push(wordTab[i]);
      tick();
      expect_word(wordTab[i]);
    end
    $display("test bypass done");
    priAmpAboveHigh = 4'h5;
    redAmpAboveHigh = 4'ha;
    txSkewBufErrIn  = 4'h9;
    tick();
    check(primarySignalDetect, 4'h5);
    check(redundantSignalDetect, 4'ha);
    check(txSkewBufferError, 4'h9);
    priAmpAboveHigh = 4'h0;
    redAmpAboveHigh = 4'h0;
    tick();
    check(primarySignalDetect, 4'h5);
    priAmpBelowLow = 4'h1;
    redAmpBelowLow = 4'h8;
    txSkewBufErrIn = 4'h0;
    tick();
    check(primarySignalDetect, 4'h4);
    check(redundantSignalDetect, 4'h2);
    check(txSkewBufferError, 4'h0);
    priAmpAboveHigh = 4'hf;
    step(10);
    check(primarySignalDetect, 4'h4);
    tick();
    check(primarySignalDetect, 4'hf);
    $display("test signal detect done");
    primaryTxEnable   = 4'h3;
    redundantTxEnable = 4'hc;
    step(5);
    check(primarySerialOutEn, 4'h3);
    check(redundantSerialOutEn, 4'hc);
    $display("test tx enable done");
    step(8);
    rxSourceSelect = '0;
    step(8);
    loopbackControl = {NC{2'h2}};
    step(8);
    loopbackControl = {NC{2'h1}};
    step(5);
    check(parallelLoopEnable, 4'hf);
    loopbackControl = '0;
    step(5);
    check(parallelLoopEnable, 4'h0);
    $display("test serial paths done");
    rxTimingSelect = `SRP_RM_OWN_REC;
    step(40);
    rxTimingSelect = `SRP_RM_CHA_REC;
    step(40);
    rxTimingSelect = `SRP_RM_REF_NOCLK;
    step(6);
    check(recoveredClockOut, 4'h0);
    check(recoveredClockOutInv, 4'hf);
    rxTimingSelect = `SRP_RM_OWN_REC;
    halfRateSelect = 1'b1;
    step(8);
    n = 0;
    prev = recoveredClockOut[0];
    for (i = 0; i < 64; i++) begin
      step(1);
      if (recoveredClockOut[0] === 1'b1 && prev === 1'b0) n++;
      prev = recoveredClockOut[0];
    end
    check(n, 4);
    halfRateSelect = 1'b0;
    push(wordTab[2]);
    step(24);
    expect_word(wordTab[2]);
    $display("test recovered clock done");
    tally_and_finish();
  end

  initial begin
    #100000;
    miscompares++;
    $display("[FAIL] %0t run did not complete", $time);
    tally_and_finish();
  end
endmodule : testbench
